// ---- common/pci_cfg_map.vh ----
// Constants for the PCI configuration command/status and class/revision logic.
// Assumes byte addresses within configuration space and 32-bit configuration data.
// Behaviour
// - Capabilities pointer and power management are valid only while new-capabilities enable is set.
// - New-capabilities enable loads from EEPROM at reset, or from strap if EEPROM disabled.
// - Fast back-to-back enable bit 9 is stored; master never does fast back-to-back.
// - System-error and parity-response both set: address parity error as target asserts SERR#.
// - Both set and parity-error select clear: own master data parity error asserts SERR#.
// - Parity-error response bit 6 set: target data parity error asserts PERR#.
// - Parity-error response set: as initiator, sample target's PERR# for data parity errors.
// - Parity-error response clear: ignore parity errors, drive neither SERR# nor PERR#.
// - Bus is requested and used as master only while bus-master enable bit 2 is set.
// - Memory-space transactions are claimed only while memory-space enable bit 1 is set.
// - I/O-space transactions are claimed only while I/O-space enable bit 0 is set.
// - Class register at offset 08h is read-only; bits 31-24 return base class 02h.
// - Bits 23-16 return a constant subclass code for an Ethernet controller.
// - Bits 15-8 return a constant programming-interface code for first interface release.
// - Bits 7-0 return a fixed silicon revision code, readable but not writable.
// - Sticky status bits 24 and 27-31 clear on writing one; writing zero leaves them unchanged.
`ifndef PCI_CFG_MAP_VH
`define PCI_CFG_MAP_VH

`define OFS_COMMAND_STATUS  8'h04
`define OFS_CLASS_REVISION  8'h08

// Command half bit positions
`define BIT_IO_SPACE        0
`define BIT_MEM_SPACE       1
`define BIT_BUS_MASTER      2
`define BIT_PERR_RESPONSE   6
`define BIT_SERR_ENABLE     8
`define BIT_FBB_ENABLE      9

// Status half bit positions
`define BIT_NEW_CAP         20
`define BIT_FBB_CAPABLE     23
`define BIT_DATA_PAR_DET    24
`define BIT_DEVSEL_LO       25
`define BIT_DEVSEL_HI       26
`define BIT_SENT_TABORT     27
`define BIT_RCV_TABORT      28
`define BIT_RCV_MABORT      29
`define BIT_SIG_SERR        30
`define BIT_DET_PERR        31

// Order of the sticky status flags inside the flag vector
`define FLAG_DATA_PAR_DET   0
`define FLAG_SENT_TABORT    1
`define FLAG_RCV_TABORT     2
`define FLAG_RCV_MABORT     3
`define FLAG_SIG_SERR       4
`define FLAG_DET_PERR       5
`define FLAG_COUNT          6

// Fixed status fields
`define DEVSEL_MEDIUM       2'h1
`define FBB_CAPABLE_VAL     1'h1

// Class register layout and fixed values
`define CLASS_BASE_HI       31
`define CLASS_BASE_LO       24
`define CLASS_SUB_HI        23
`define CLASS_SUB_LO        16
`define CLASS_PROG_HI       15
`define CLASS_PROG_LO       8
`define CLASS_REV_HI        7
`define CLASS_REV_LO        0
`define BASE_CLASS_NETWORK  8'h02

// Byte lanes
`define LANE_CMD_LO         0
`define LANE_CMD_HI         1
`define LANE_STAT_LO        2
`define LANE_STAT_HI        3

// Reset values
`define ZERO_WORD           32'h00000000
`define SETTLE_CYCLES       2'h2
`define SETTLE_ZERO         2'h0
`define SETTLE_STEP         2'h1

`endif

// ---- rtl/sync2.v ----
// Two-stage synchroniser for pin-level inputs.
// Assumes the inputs are slow levels; the first stage feeds only the second.
`timescale 1ns/100ps
module sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             resetn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage_one;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            stage_one <= {WIDTH{1'b0}};
            sync_out  <= {WIDTH{1'b0}};
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule

// ---- rtl/status_flag.v ----
// One sticky status bit, set by hardware and cleared by software.
// Assumes set and clear are one-cycle pulses on clk_sys.
`timescale 1ns/100ps
module status_flag (
    input  wire clk_sys,
    input  wire resetn,
    input  wire set,
    input  wire clear,
    output reg  flag
);
    always @(posedge clk_sys) begin
        if (!resetn) begin
            flag <= 1'b0;
        end else begin
            // Set wins, so an event in the clearing cycle is kept
            flag <= set | (flag & ~clear);
        end
    end
endmodule

// ---- rtl/pci_cfg_regs.v ----
// Configuration command/status and class/revision registers of a PCI network controller.
// Assumes a configuration-cycle decoder on clk_sys presents one request pulse per access,
// and that the PCI target/master engines report parity and abort events as pulses.
`timescale 1ns/100ps
`include "pci_cfg_map.vh"
module pci_cfg_regs #(
    // Arbitrary values
    parameter [7:0] SUB_CLASS_CODE   = 8'h5a,
    parameter [7:0] PROG_IF_CODE     = 8'h3c,
    parameter [7:0] SILICON_REVISION = 8'h7e
) (
    input  wire        clk_sys,
    input  wire        resetn,
    // Configuration access port
    input  wire        cfg_req,
    input  wire        cfg_write,
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg         cfg_ack,
    output reg  [31:0] cfg_rdata,
    // New-capabilities source
    input  wire        eeprom_present_pin,
    input  wire        new_cap_strap_pin,
    input  wire        eeprom_load_valid,
    input  wire        eeprom_new_cap,
    output reg         new_capabilities_enable,
    output reg         cap_loading,
    // Parity and abort events
    input  wire        tgt_addr_parity_err,
    input  wire        tgt_data_parity_err,
    input  wire        mst_data_parity_err,
    input  wire        mst_write_data_phase,
    input  wire        parity_error_select,
    input  wire        rcv_master_abort,
    input  wire        rcv_target_abort,
    input  wire        sent_target_abort,
    output reg         master_parity_error,
    // Open-drain error pins
    input  wire        perr_n_in,
    output reg         perr_n_out,
    output reg         perr_n_oe,
    output reg         serr_n_out,
    output reg         serr_n_oe,
    // Master and target gating
    input  wire        master_req_in,
    output wire        bus_req,
    output reg         master_fbb_allowed,
    input  wire        mem_hit,
    input  wire        io_hit,
    output wire        mem_claim,
    output wire        io_claim,
    // Command state for the rest of the device
    output reg         bus_master_enable,
    output reg         memory_space_enable,
    output reg         io_space_enable,
    output reg         parity_error_response,
    output reg         system_error_enable,
    output reg         fast_back_to_back_enable
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    wire [2:0] pins_sync;
    wire       eeprom_present;
    wire       new_cap_strap;
    wire       perr_n_sync;

    sync2 #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in ({perr_n_in, new_cap_strap_pin, eeprom_present_pin}),
        .sync_out (pins_sync)
    );

    assign eeprom_present = pins_sync[0];
    assign new_cap_strap  = pins_sync[1];
    // Synchroniser resets low; PERR# is only looked at in write data phases
    assign perr_n_sync    = pins_sync[2];

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    wire sel_cs;
    wire sel_cr;
    wire wr_cs;

    assign sel_cs = (cfg_addr == `OFS_COMMAND_STATUS);
    assign sel_cr = (cfg_addr == `OFS_CLASS_REVISION);
    assign wr_cs  = cfg_req & cfg_write & sel_cs;

    // ------------------------------------------------------------------
    // New-capabilities enable load after reset
    // ------------------------------------------------------------------
    reg [1:0] settle;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            settle                  <= `SETTLE_ZERO;
            cap_loading             <= 1'b1;
            new_capabilities_enable <= 1'b0;
        end else if (cap_loading) begin
            // Straps pass the synchroniser before they may be trusted
            if (settle != `SETTLE_CYCLES) begin
                settle <= settle + `SETTLE_STEP;
            end else if (!eeprom_present) begin
                new_capabilities_enable <= new_cap_strap;
                cap_loading             <= 1'b0;
            end else if (eeprom_load_valid) begin
                new_capabilities_enable <= eeprom_new_cap;
                cap_loading             <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command half
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn) begin
            io_space_enable          <= 1'b0;
            memory_space_enable      <= 1'b0;
            bus_master_enable        <= 1'b0;
            parity_error_response    <= 1'b0;
            system_error_enable      <= 1'b0;
            fast_back_to_back_enable <= 1'b0;
        end else if (wr_cs) begin
            if (cfg_be[`LANE_CMD_LO]) begin
                io_space_enable       <= cfg_wdata[`BIT_IO_SPACE];
                memory_space_enable   <= cfg_wdata[`BIT_MEM_SPACE];
                bus_master_enable     <= cfg_wdata[`BIT_BUS_MASTER];
                parity_error_response <= cfg_wdata[`BIT_PERR_RESPONSE];
            end
            if (cfg_be[`LANE_CMD_HI]) begin
                system_error_enable      <= cfg_wdata[`BIT_SERR_ENABLE];
                fast_back_to_back_enable <= cfg_wdata[`BIT_FBB_ENABLE];
            end
        end
    end

    // Fast back-to-back is recorded but never used as master
    always @(posedge clk_sys) begin
        if (!resetn) begin
            master_fbb_allowed <= 1'b0;
        end else begin
            master_fbb_allowed <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Master and target gating
    // ------------------------------------------------------------------
    assign bus_req   = master_req_in & bus_master_enable;
    assign mem_claim = mem_hit & memory_space_enable;
    assign io_claim  = io_hit & io_space_enable;

    // ------------------------------------------------------------------
    // Parity error handling
    // ------------------------------------------------------------------
    wire perr_sampled;
    wire master_parity_event;
    wire serr_fire;
    wire perr_fire;
    wire any_parity;

    // Target reports its data parity error on PERR# during our write data phase
    assign perr_sampled = parity_error_response & mst_write_data_phase & ~perr_n_sync;

    assign master_parity_event = parity_error_response
                               & (mst_data_parity_err | perr_sampled);

    assign serr_fire = system_error_enable & parity_error_response
                     & (tgt_addr_parity_err
                     | (master_parity_event & ~parity_error_select));

    assign perr_fire = parity_error_response & tgt_data_parity_err;

    // Detected-parity status follows the response bit, so a disabled device shows nothing
    assign any_parity = parity_error_response
                      & (tgt_addr_parity_err | tgt_data_parity_err
                      | mst_data_parity_err);

    always @(posedge clk_sys) begin
        if (!resetn) begin
            serr_n_out          <= 1'b0;
            serr_n_oe           <= 1'b0;
            perr_n_out          <= 1'b0;
            perr_n_oe           <= 1'b0;
            master_parity_error <= 1'b0;
        end else begin
            // Open drain: the level is always low, only the enable moves
            serr_n_out          <= 1'b0;
            perr_n_out          <= 1'b0;
            serr_n_oe           <= serr_fire;
            perr_n_oe           <= perr_fire;
            master_parity_error <= master_parity_event;
        end
    end

    // ------------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------------
    wire [`FLAG_COUNT-1:0] flag_set;
    wire [`FLAG_COUNT-1:0] flag_clear;
    wire [`FLAG_COUNT-1:0] flag;
    wire [`FLAG_COUNT-1:0] clear_bits;

    assign flag_set[`FLAG_DATA_PAR_DET] = master_parity_event;
    assign flag_set[`FLAG_SENT_TABORT]  = sent_target_abort;
    assign flag_set[`FLAG_RCV_TABORT]   = rcv_target_abort;
    assign flag_set[`FLAG_RCV_MABORT]   = rcv_master_abort;
    assign flag_set[`FLAG_SIG_SERR]     = serr_fire;
    assign flag_set[`FLAG_DET_PERR]     = any_parity;

    assign clear_bits[`FLAG_DATA_PAR_DET] = cfg_be[`LANE_STAT_HI] & cfg_wdata[`BIT_DATA_PAR_DET];
    assign clear_bits[`FLAG_SENT_TABORT]  = cfg_be[`LANE_STAT_HI] & cfg_wdata[`BIT_SENT_TABORT];
    assign clear_bits[`FLAG_RCV_TABORT]   = cfg_be[`LANE_STAT_HI] & cfg_wdata[`BIT_RCV_TABORT];
    assign clear_bits[`FLAG_RCV_MABORT]   = cfg_be[`LANE_STAT_HI] & cfg_wdata[`BIT_RCV_MABORT];
    assign clear_bits[`FLAG_SIG_SERR]     = cfg_be[`LANE_STAT_HI] & cfg_wdata[`BIT_SIG_SERR];
    assign clear_bits[`FLAG_DET_PERR]     = cfg_be[`LANE_STAT_HI] & cfg_wdata[`BIT_DET_PERR];

    assign flag_clear = clear_bits & {`FLAG_COUNT{wr_cs}};

    genvar gi;
    generate
        for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1) begin : g_flag
            status_flag u_flag (
                .clk_sys (clk_sys),
                .resetn  (resetn),
                .set     (flag_set[gi]),
                .clear   (flag_clear[gi]),
                .flag    (flag[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    reg [31:0] cs_word;
    reg [31:0] cr_word;
    reg [31:0] next_rdata;

    always @* begin
        cs_word                       = `ZERO_WORD;
        cs_word[`BIT_IO_SPACE]        = io_space_enable;
        cs_word[`BIT_MEM_SPACE]       = memory_space_enable;
        cs_word[`BIT_BUS_MASTER]      = bus_master_enable;
        cs_word[`BIT_PERR_RESPONSE]   = parity_error_response;
        cs_word[`BIT_SERR_ENABLE]     = system_error_enable;
        cs_word[`BIT_FBB_ENABLE]      = fast_back_to_back_enable;
        cs_word[`BIT_NEW_CAP]         = new_capabilities_enable;
        cs_word[`BIT_FBB_CAPABLE]     = `FBB_CAPABLE_VAL;
        cs_word[`BIT_DATA_PAR_DET]    = flag[`FLAG_DATA_PAR_DET];
        cs_word[`BIT_DEVSEL_HI:`BIT_DEVSEL_LO] = `DEVSEL_MEDIUM;
        cs_word[`BIT_SENT_TABORT]     = flag[`FLAG_SENT_TABORT];
        cs_word[`BIT_RCV_TABORT]      = flag[`FLAG_RCV_TABORT];
        cs_word[`BIT_RCV_MABORT]      = flag[`FLAG_RCV_MABORT];
        cs_word[`BIT_SIG_SERR]        = flag[`FLAG_SIG_SERR];
        cs_word[`BIT_DET_PERR]        = flag[`FLAG_DET_PERR];
    end

    // Class/revision has no storage, so a write cannot touch it
    always @* begin
        cr_word = `ZERO_WORD;
        cr_word[`CLASS_BASE_HI:`CLASS_BASE_LO] = `BASE_CLASS_NETWORK;
        cr_word[`CLASS_SUB_HI:`CLASS_SUB_LO]   = SUB_CLASS_CODE;
        cr_word[`CLASS_PROG_HI:`CLASS_PROG_LO] = PROG_IF_CODE;
        cr_word[`CLASS_REV_HI:`CLASS_REV_LO]   = SILICON_REVISION;
    end

    always @* begin
        next_rdata = `ZERO_WORD;
        if (cfg_req && !cfg_write) begin
            if (sel_cs) begin
                next_rdata = cs_word;
            end else if (sel_cr) begin
                next_rdata = cr_word;
            end
        end
    end

    // Every request, read or write, mapped or not, is acknowledged one cycle later
    always @(posedge clk_sys) begin
        if (!resetn) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= `ZERO_WORD;
        end else begin
            cfg_ack <= cfg_req;
            if (cfg_req && !cfg_write) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

endmodule

// ---- tb/pci_cfg_regs_sva.sv ----
// Checker for the configuration command/status and class/revision logic.
// Assumes it is bound to pci_cfg_regs and sees only that module's ports.
`timescale 1ns/100ps
module pci_cfg_regs_chk (
    input wire        clk_sys,
    input wire        resetn,
    input wire        cfg_req,
    input wire        cfg_write,
    input wire [7:0]  cfg_addr,
    input wire        cfg_ack,
    input wire [31:0] cfg_rdata,
    input wire        tgt_addr_parity_err,
    input wire        tgt_data_parity_err,
    input wire        mst_data_parity_err,
    input wire        parity_error_select,
    input wire        perr_n_oe,
    input wire        serr_n_oe,
    input wire        master_req_in,
    input wire        bus_req,
    input wire        master_fbb_allowed,
    input wire        mem_hit,
    input wire        io_hit,
    input wire        mem_claim,
    input wire        io_claim,
    input wire        bus_master_enable,
    input wire        memory_space_enable,
    input wire        io_space_enable,
    input wire        parity_error_response,
    input wire        system_error_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_ack_after_req: assert property (cfg_ack == $past(cfg_req))
        else $error("ack late");
    a_bus_req_gate: assert property (bus_req == (master_req_in && bus_master_enable))
        else $error("bus_req gate");
    a_mem_claim_gate: assert property (mem_claim == (mem_hit && memory_space_enable))
        else $error("mem_claim gate");
    a_io_claim_gate: assert property (io_claim == (io_hit && io_space_enable))
        else $error("io_claim gate");
    a_no_fbb_master: assert property (!master_fbb_allowed)
        else $error("fbb as master");
    a_addr_par_serr: assert property (tgt_addr_parity_err && system_error_enable
        && parity_error_response |=> serr_n_oe) else $error("serr on addr parity");
    a_mst_par_serr: assert property (mst_data_parity_err && system_error_enable
        && parity_error_response && !parity_error_select |=> serr_n_oe)
        else $error("serr on master parity");
    a_tgt_par_perr: assert property (tgt_data_parity_err && parity_error_response
        |=> perr_n_oe) else $error("perr on target parity");
    a_quiet_no_resp: assert property (!parity_error_response |=> !perr_n_oe && !serr_n_oe)
        else $error("pin with response off");
    a_serr_needs_en: assert property (!system_error_enable |=> !serr_n_oe)
        else $error("serr while disabled");
    a_class_base: assert property (cfg_req && !cfg_write && cfg_addr == 8'h08
        |=> cfg_rdata[31:24] == 8'h02) else $error("base class wrong");

    c_write: cover property (cfg_req && cfg_write);
    c_serr: cover property (serr_n_oe);
    c_perr: cover property (perr_n_oe);
    c_bus_req: cover property (bus_req);
endmodule

bind pci_cfg_regs pci_cfg_regs_chk u_chk (.clk_sys, .resetn, .cfg_req, .cfg_write, .cfg_addr,
    .cfg_ack, .cfg_rdata, .tgt_addr_parity_err, .tgt_data_parity_err, .mst_data_parity_err,
    .parity_error_select, .perr_n_oe, .serr_n_oe, .master_req_in, .bus_req,
    .master_fbb_allowed, .mem_hit, .io_hit, .mem_claim, .io_claim, .bus_master_enable,
    .memory_space_enable, .io_space_enable, .parity_error_response, .system_error_enable);

// ---- tb/cfg_host.sv ----
// Host bridge model: configuration software issuing one access per request pulse.
// Assumes the device acks each request one clock after taking it.
`timescale 1ns/100ps
module cfg_host (
    input  wire        clk_sys,
    input  wire        cfg_ack,
    input  wire [31:0] cfg_rdata,
    output reg         cfg_req = 1'b0,
    output reg         cfg_write = 1'b0,
    output reg  [7:0]  cfg_addr = 8'h00,
    output reg  [3:0]  cfg_be = 4'h0,
    output reg  [31:0] cfg_wdata = 32'h00000000
);
    task access(input wr, input [7:0] a, input [3:0] be, input [31:0] wd,
                output [31:0] rd, output ok);
        integer n;
        begin
            ok = 1'b0;
            rd = 32'h00000000;
            @(posedge clk_sys);
            cfg_req <= 1'b1;
            cfg_write <= wr;
            cfg_addr <= a;
            cfg_be <= be;
            cfg_wdata <= wd;
            @(posedge clk_sys);
            cfg_req <= 1'b0;
            for (n = 0; n < 4 && !ok; n = n + 1) begin
                #1;
                if (cfg_ack === 1'b1) begin
                    ok = 1'b1;
                    rd = cfg_rdata;
                end else begin
                    @(posedge clk_sys);
                end
            end
        end
    endtask
endmodule

// ---- tb/test_pci_cfg_regs.sv ----
// Self-checking bench for the configuration command/status and class registers.
// Assumes cfg_host drives the configuration port and the checker is bound.
`timescale 1ns/100ps
module test_pci_cfg_regs;
    reg         clk_sys, resetn, eeprom_present_pin, new_cap_strap_pin;
    reg         eeprom_load_valid, eeprom_new_cap, mst_write_data_phase;
    reg         parity_error_select, perr_n_in, master_req_in, mem_hit, io_hit;
    reg  [5:0]  ev;
    reg  [31:0] rd;
    reg         ok;
    integer     err_total, samples_checked, cyc;
    wire        cfg_req, cfg_write, cfg_ack, new_capabilities_enable, cap_loading;
    wire        master_parity_error, perr_n_out, perr_n_oe, serr_n_out, serr_n_oe;
    wire        bus_req, master_fbb_allowed, mem_claim, io_claim, bus_master_enable;
    wire        memory_space_enable, io_space_enable, parity_error_response;
    wire        system_error_enable, fast_back_to_back_enable;
    wire [7:0]  cfg_addr;
    wire [3:0]  cfg_be;
    wire [31:0] cfg_wdata, cfg_rdata;

    cfg_host host (.clk_sys, .cfg_ack, .cfg_rdata, .cfg_req, .cfg_write, .cfg_addr, .cfg_be,
        .cfg_wdata);

    pci_cfg_regs DUT (.clk_sys, .resetn, .cfg_req, .cfg_write, .cfg_addr, .cfg_be,
        .cfg_wdata, .cfg_ack, .cfg_rdata, .eeprom_present_pin, .new_cap_strap_pin,
        .eeprom_load_valid, .eeprom_new_cap, .new_capabilities_enable, .cap_loading,
        .tgt_addr_parity_err(ev[0]), .tgt_data_parity_err(ev[1]),
        .mst_data_parity_err(ev[2]), .mst_write_data_phase, .parity_error_select,
        .rcv_master_abort(ev[3]), .rcv_target_abort(ev[4]), .sent_target_abort(ev[5]),
        .master_parity_error, .perr_n_in, .perr_n_out, .perr_n_oe, .serr_n_out, .serr_n_oe,
        .master_req_in, .bus_req, .master_fbb_allowed, .mem_hit, .io_hit, .mem_claim,
        .io_claim, .bus_master_enable, .memory_space_enable, .io_space_enable,
        .parity_error_response, .system_error_enable, .fast_back_to_back_enable);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task conclude;
        begin
            $display("checked %0d mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // Ceiling far above the roughly 90-cycle run
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            err_total = err_total + 1;
            conclude;
        end
    end

    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task rd_chk(input [7:0] a, input [31:0] exp);
        begin
            host.access(1'b0, a, 4'hf, 32'h00000000, rd, ok);
            chk("read ack", 32'h1, {31'h0, ok});
            chk("read data", exp, rd);
        end
    endtask

    task wr(input [7:0] a, input [3:0] be, input [31:0] d);
        begin
            host.access(1'b1, a, be, d, rd, ok);
            chk("write ack", 32'h1, {31'h0, ok});
        end
    endtask

    task pulse(input [5:0] m);
        begin
            @(posedge clk_sys);
            ev <= m;
            @(posedge clk_sys);
            ev <= 6'h00;
            #1;
        end
    endtask

    task do_reset(input present, input strap);
        begin
            @(posedge clk_sys);
            resetn <= 1'b0;
            eeprom_present_pin <= present;
            new_cap_strap_pin <= strap;
            repeat (6) @(posedge clk_sys);
            resetn <= 1'b1;
            #1;
            chk("loading", 32'h1, {31'h0, cap_loading});
        end
    endtask

    task t_strap_class;
        begin
            do_reset(1'b0, 1'b1);
            repeat (4) @(posedge clk_sys);
            #1;
            chk("new cap", 32'h1, {31'h0, new_capabilities_enable});
            rd_chk(8'h04, 32'h02900000);
            rd_chk(8'h08, 32'h025a3c7e);
            wr(8'h08, 4'hf, 32'hffffffff);
            rd_chk(8'h08, 32'h025a3c7e);
            rd_chk(8'h0c, 32'h00000000);
            $display("test strap_class done");
        end
    endtask

    task t_command;
        begin
            wr(8'h04, 4'h3, 32'h00000347);
            rd_chk(8'h04, 32'h02900347);
            @(posedge clk_sys);
            master_req_in <= 1'b1;
            mem_hit <= 1'b1;
            io_hit <= 1'b1;
            @(posedge clk_sys);
            #1;
            chk("gates on", 32'he, {28'h0, bus_req, mem_claim, io_claim, master_fbb_allowed});
            wr(8'h04, 4'h1, 32'h00000000);
            chk("gates off", 32'h0, {29'h0, bus_req, mem_claim, io_claim});
            rd_chk(8'h04, 32'h02900300);
            @(posedge clk_sys);
            master_req_in <= 1'b0;
            mem_hit <= 1'b0;
            io_hit <= 1'b0;
            $display("test command done");
        end
    endtask

    task t_parity;
        begin
            wr(8'h04, 4'hf, 32'h00000140);
            pulse(6'h01);
            chk("serr addr", 32'h1, {31'h0, serr_n_oe});
            rd_chk(8'h04, 32'hc2900140);
            wr(8'h04, 4'h8, 32'hc0000000);
            rd_chk(8'h04, 32'h02900140);
            pulse(6'h02);
            chk("perr tgt", 32'h1, {31'h0, perr_n_oe});
            pulse(6'h04);
            chk("serr mst", 32'h3, {30'h0, serr_n_oe, master_parity_error});
            rd_chk(8'h04, 32'hc3900140);
            wr(8'h04, 4'h8, 32'hff000000);
            @(posedge clk_sys);
            mst_write_data_phase <= 1'b1;
            perr_n_in <= 1'b0;
            @(posedge clk_sys);
            perr_n_in <= 1'b1;
            repeat (4) @(posedge clk_sys);
            mst_write_data_phase <= 1'b0;
            host.access(1'b0, 8'h04, 4'hf, 32'h00000000, rd, ok);
            chk("sampled perr", 32'h1, {31'h0, rd[24]});
            wr(8'h04, 4'h8, 32'hff000000);
            @(posedge clk_sys);
            parity_error_select <= 1'b1;
            pulse(6'h04);
            chk("serr pesel", 32'h0, {31'h0, serr_n_oe});
            wr(8'h04, 4'hf, 32'hff000100);
            pulse(6'h07);
            chk("quiet pins", 32'h0, {30'h0, perr_n_oe, serr_n_oe});
            pulse(6'h38);
            rd_chk(8'h04, 32'h3a900100);
            $display("test parity done");
        end
    endtask

    task t_eeprom;
        begin
            do_reset(1'b1, 1'b1);
            repeat (4) @(posedge clk_sys);
            #1;
            chk("waiting", 32'h1, {31'h0, cap_loading});
            @(posedge clk_sys);
            eeprom_load_valid <= 1'b1;
            eeprom_new_cap <= 1'b0;
            @(posedge clk_sys);
            eeprom_load_valid <= 1'b0;
            #1;
            chk("eeprom cap", 32'h0, {30'h0, cap_loading, new_capabilities_enable});
            rd_chk(8'h04, 32'h02800000);
            $display("test eeprom done");
        end
    endtask

    initial begin
        resetn = 1'b0;
        eeprom_present_pin = 1'b0;
        new_cap_strap_pin = 1'b1;
        eeprom_load_valid = 1'b0;
        eeprom_new_cap = 1'b0;
        mst_write_data_phase = 1'b0;
        parity_error_select = 1'b0;
        perr_n_in = 1'b1;
        master_req_in = 1'b0;
        mem_hit = 1'b0;
        io_hit = 1'b0;
        ev = 6'h00;
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        t_strap_class;
        t_command;
        t_parity;
        t_eeprom;
        conclude;
    end
endmodule
